// >>> logic/flsc_defs.vh
`ifndef FLSC_DEFS_VH
`define FLSC_DEFS_VH

// Clock and flash bus timing
`define FLSC_CLK_NS        25
`define FLSC_T_ACC_NS      90
`define FLSC_ACC_CYC       ((`FLSC_T_ACC_NS + `FLSC_CLK_NS - 1) / `FLSC_CLK_NS)
`define FLSC_T_WP_NS       45
`define FLSC_WP_CYC        ((`FLSC_T_WP_NS + `FLSC_CLK_NS - 1) / `FLSC_CLK_NS)
`define FLSC_T_OEH_NS      10
`define FLSC_OEH_CYC       ((`FLSC_T_OEH_NS + `FLSC_CLK_NS - 1) / `FLSC_CLK_NS)

// APB register word offsets
`define FLSC_REG_CTRL      6'h00
`define FLSC_REG_ADDR      6'h01
`define FLSC_REG_WDATA     6'h02
`define FLSC_REG_STATUS    6'h03
`define FLSC_REG_RDATA     6'h04

// Control fields
`define FLSC_CTRL_START    3
`define FLSC_CTRL_POLL     4

// Operations
`define FLSC_OP_READ       3'h0
`define FLSC_OP_PROG       3'h1
`define FLSC_OP_SECT       3'h2
`define FLSC_OP_ADD        3'h3
`define FLSC_OP_CHIP       3'h4
`define FLSC_OP_SUSP       3'h5
`define FLSC_OP_RESUME     3'h6
`define FLSC_OP_RESET      3'h7

// Flash command bytes and unlock addresses
`define FLSC_UNLOCK_A1     19'h00555
`define FLSC_UNLOCK_A2     19'h002aa
`define FLSC_CMD_UNLOCK1   8'haa
`define FLSC_CMD_UNLOCK2   8'h55
`define FLSC_CMD_PROG      8'ha0
`define FLSC_CMD_ERASE     8'h80
`define FLSC_CMD_CHIP      8'h10
`define FLSC_CMD_SECT      8'h30
`define FLSC_CMD_SUSP      8'hb0
`define FLSC_CMD_RESUME    8'h30
`define FLSC_CMD_RESET     8'hf0

// Status byte bit positions
`define FLSC_BIT_GTOGGLE   6
`define FLSC_BIT_TLFAIL    5
`define FLSC_BIT_EWCLOSED  3

`endif

// >>> logic/flsc_bus_cycle.v
`timescale 1ns/10ps
`include "flsc_defs.vh"
module flsc_bus_cycle (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        go,
    input  wire        wr,
    input  wire [18:0] addr,
    input  wire [7:0]  wdata,
    input  wire [7:0]  fl_dq_i,
    output reg         done,
    output reg  [7:0]  rdata,
    output reg  [18:0] fl_addr,
    output reg  [7:0]  fl_dq_o,
    output reg         fl_dq_oe,
    output reg         fl_ce_n,
    output reg         fl_oe_n,
    output reg         fl_we_n
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SET  = 4'b0010;
    localparam [3:0] S_STB  = 4'b0100;
    localparam [3:0] S_REC  = 4'b1000;
    localparam integer ACC_LAST = `FLSC_ACC_CYC - 1;
    localparam integer WP_LAST  = `FLSC_WP_CYC - 1;
    localparam integer OEH_LAST = `FLSC_OEH_CYC - 1;

    reg [3:0] state_q;
    reg [2:0] cnt_q;
    reg       wr_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= S_IDLE;
            cnt_q    <= 3'h0;
            wr_q     <= 1'b0;
            done     <= 1'b0;
            rdata    <= 8'h00;
            fl_addr  <= 19'h00000;
            fl_dq_o  <= 8'h00;
            fl_dq_oe <= 1'b0;
            fl_ce_n  <= 1'b1;
            fl_oe_n  <= 1'b1;
            fl_we_n  <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (go) begin
                        wr_q     <= wr;
                        fl_addr  <= addr;
                        fl_dq_o  <= wdata;
                        fl_dq_oe <= wr;
                        fl_ce_n  <= 1'b0;
                        state_q  <= S_SET;
                    end
                end
                S_SET: begin
                    // Address settles a full cycle before either strobe
                    fl_we_n <= ~wr_q;
                    fl_oe_n <= wr_q;
                    cnt_q   <= 3'h0;
                    state_q <= S_STB;
                end
                S_STB: begin
                    cnt_q <= cnt_q + 3'h1;
                    if ((wr_q && cnt_q == WP_LAST[2:0]) || (!wr_q && cnt_q == ACC_LAST[2:0])) begin
                        if (!wr_q) begin
                            rdata <= fl_dq_i;
                        end
                        fl_we_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        cnt_q   <= 3'h0;
                        state_q <= S_REC;
                    end
                end
                S_REC: begin
                    // Strobe high gap, so each status read is a distinct cycle
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == OEH_LAST[2:0]) begin
                        fl_ce_n  <= 1'b1;
                        fl_dq_oe <= 1'b0;
                        done     <= 1'b1;
                        state_q  <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> logic/flsc_top.v
`timescale 1ns/10ps
`include "flsc_defs.vh"
// Summary of operation
// - Poll at program address or erasing sector
// - Two reads, compare toggle; same means done
// - Toggling plus fail flag: recheck, reset if still toggling
// - Resumed polling restarts with two reads
// - After failure, write reset command
// - Window flag ignorable only under 50us spacing
// - Check window flag before and after add
// - Single F0 write returns to array read
module flsc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  fl_dq_i,
    output wire [18:0] fl_addr,
    output wire [7:0]  fl_dq_o,
    output wire        fl_dq_oe,
    output wire        fl_ce_n,
    output wire        fl_oe_n,
    output wire        fl_we_n
);
    localparam [9:0] ST_IDLE = 10'h001;
    localparam [9:0] ST_SEQ  = 10'h002;
    localparam [9:0] ST_PRE  = 10'h004;
    localparam [9:0] ST_POST = 10'h008;
    localparam [9:0] ST_PA   = 10'h010;
    localparam [9:0] ST_PB   = 10'h020;
    localparam [9:0] ST_RA   = 10'h040;
    localparam [9:0] ST_RB   = 10'h080;
    localparam [9:0] ST_FIN  = 10'h100;
    localparam [9:0] ST_RST  = 10'h200;

    reg  [9:0]  state_q;
    reg  [2:0]  op_q;
    reg         poll_q;
    reg  [2:0]  idx_q;
    reg         busy_q;
    reg         done_q;
    reg         fail_q;
    reg         rej_q;
    reg         pre_q;
    reg  [7:0]  stat_q;
    reg  [7:0]  first_q;
    reg  [7:0]  rdata_q;
    reg  [18:0] addr_q;
    reg  [7:0]  wdata_q;
    reg         go_q;
    reg         wt_q;
    reg         c_wr;
    reg  [18:0] c_addr;
    reg  [7:0]  c_data;
    reg  [31:0] rd_mux;
    reg         hit;
    wire        cyc_done;
    wire [7:0]  cyc_rdata;
    wire [5:0]  word = paddr[7:2];
    wire        acc = psel & penable & pready;
    wire        wr_en = acc & pwrite;
    wire        start = wr_en & (word == `FLSC_REG_CTRL) & pwdata[`FLSC_CTRL_START] & ~busy_q;
    wire        same = (first_q[`FLSC_BIT_GTOGGLE] == cyc_rdata[`FLSC_BIT_GTOGGLE]);

    function [18:0] seq_addr;
        input [2:0]  op;
        input [2:0]  idx;
        input [18:0] a;
        begin
            case (idx)
                3'h0: seq_addr = (op == `FLSC_OP_PROG || op == `FLSC_OP_SECT ||
                                  op == `FLSC_OP_CHIP) ? `FLSC_UNLOCK_A1 : a;
                3'h1: seq_addr = `FLSC_UNLOCK_A2;
                3'h3: seq_addr = (op == `FLSC_OP_PROG) ? a : `FLSC_UNLOCK_A1;
                3'h4: seq_addr = `FLSC_UNLOCK_A2;
                3'h5: seq_addr = (op == `FLSC_OP_SECT) ? a : `FLSC_UNLOCK_A1;
                default: seq_addr = `FLSC_UNLOCK_A1;
            endcase
        end
    endfunction

    function [7:0] seq_data;
        input [2:0] op;
        input [2:0] idx;
        input [7:0] d;
        begin
            case (idx)
                3'h0: begin
                    case (op)
                        `FLSC_OP_ADD:    seq_data = `FLSC_CMD_SECT;
                        `FLSC_OP_SUSP:   seq_data = `FLSC_CMD_SUSP;
                        `FLSC_OP_RESUME: seq_data = `FLSC_CMD_RESUME;
                        `FLSC_OP_RESET:  seq_data = `FLSC_CMD_RESET;
                        default:         seq_data = `FLSC_CMD_UNLOCK1;
                    endcase
                end
                3'h1: seq_data = `FLSC_CMD_UNLOCK2;
                3'h2: seq_data = (op == `FLSC_OP_PROG) ? `FLSC_CMD_PROG : `FLSC_CMD_ERASE;
                3'h3: seq_data = (op == `FLSC_OP_PROG) ? d : `FLSC_CMD_UNLOCK1;
                3'h4: seq_data = `FLSC_CMD_UNLOCK2;
                default: seq_data = (op == `FLSC_OP_SECT) ? `FLSC_CMD_SECT : `FLSC_CMD_CHIP;
            endcase
        end
    endfunction

    function [2:0] seq_last;
        input [2:0] op;
        begin
            case (op)
                `FLSC_OP_PROG: seq_last = 3'h3;
                `FLSC_OP_SECT: seq_last = 3'h5;
                `FLSC_OP_CHIP: seq_last = 3'h5;
                default:       seq_last = 3'h0;
            endcase
        end
    endfunction

    flsc_bus_cycle u_cycle (
        .pclk     (pclk),
        .presetn  (presetn),
        .go       (go_q),
        .wr       (c_wr),
        .addr     (c_addr),
        .wdata    (c_data),
        .fl_dq_i  (fl_dq_i),
        .done     (cyc_done),
        .rdata    (cyc_rdata),
        .fl_addr  (fl_addr),
        .fl_dq_o  (fl_dq_o),
        .fl_dq_oe (fl_dq_oe),
        .fl_ce_n  (fl_ce_n),
        .fl_oe_n  (fl_oe_n),
        .fl_we_n  (fl_we_n)
    );

    // Status reads always go to the target address so sector bits are valid
    always @* begin
        c_wr   = 1'b0;
        c_addr = addr_q;
        c_data = wdata_q;
        case (state_q)
            ST_SEQ: begin
                c_wr   = 1'b1;
                c_addr = seq_addr(op_q, idx_q, addr_q);
                c_data = seq_data(op_q, idx_q, wdata_q);
            end
            ST_RST: begin
                c_wr   = 1'b1;
                c_data = `FLSC_CMD_RESET;
            end
            default: begin
                c_wr = 1'b0;
            end
        endcase
    end

    always @* begin
        hit = 1'b1;
        case (word)
            `FLSC_REG_CTRL:   rd_mux = {27'h0, poll_q, 1'b0, op_q};
            `FLSC_REG_ADDR:   rd_mux = {13'h0, addr_q};
            `FLSC_REG_WDATA:  rd_mux = {24'h0, wdata_q};
            `FLSC_REG_STATUS: rd_mux = {16'h0, stat_q, 3'h0, pre_q, rej_q, fail_q, done_q, busy_q};
            `FLSC_REG_RDATA:  rd_mux = {24'h0, rdata_q};
            default: begin
                rd_mux = 32'h0;
                hit    = 1'b0;
            end
        endcase
    end

    // One wait state per access keeps every bus output registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            addr_q  <= 19'h0;
            wdata_q <= 8'h00;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= rd_mux;
            pslverr <= psel & penable & ~pready & (~hit | (pwrite & busy_q &
                       (word == `FLSC_REG_CTRL || word == `FLSC_REG_ADDR ||
                        word == `FLSC_REG_WDATA)));
            // Operands are frozen while an operation runs
            if (wr_en && !busy_q && word == `FLSC_REG_ADDR) begin
                addr_q <= pwdata[18:0];
            end
            if (wr_en && !busy_q && word == `FLSC_REG_WDATA) begin
                wdata_q <= pwdata[7:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            op_q    <= `FLSC_OP_READ;
            poll_q  <= 1'b0;
            idx_q   <= 3'h0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            fail_q  <= 1'b0;
            rej_q   <= 1'b0;
            pre_q   <= 1'b0;
            stat_q  <= 8'h00;
            first_q <= 8'h00;
            rdata_q <= 8'h00;
            go_q    <= 1'b0;
            wt_q    <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (state_q != ST_IDLE && !wt_q) begin
                go_q <= 1'b1;
                wt_q <= 1'b1;
            end
            if (cyc_done) begin
                wt_q <= 1'b0;
            end
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        op_q   <= pwdata[2:0];
                        poll_q <= pwdata[`FLSC_CTRL_POLL];
                        idx_q  <= 3'h0;
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        fail_q <= 1'b0;
                        rej_q  <= 1'b0;
                        if (pwdata[2:0] == `FLSC_OP_READ) begin
                            state_q <= pwdata[`FLSC_CTRL_POLL] ? ST_PA : ST_FIN;
                        end else if (pwdata[2:0] == `FLSC_OP_ADD) begin
                            state_q <= ST_PRE;
                        end else begin
                            state_q <= ST_SEQ;
                        end
                    end
                end
                ST_SEQ: begin
                    if (cyc_done) begin
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == seq_last(op_q)) begin
                            idx_q <= 3'h0;
                            if (op_q == `FLSC_OP_ADD) begin
                                state_q <= ST_POST;
                            end else if (poll_q && op_q != `FLSC_OP_RESET) begin
                                state_q <= ST_PA;
                            end else begin
                                state_q <= ST_IDLE;
                                busy_q  <= 1'b0;
                                done_q  <= 1'b1;
                            end
                        end
                    end
                end
                ST_PRE: begin
                    if (cyc_done) begin
                        pre_q   <= cyc_rdata[`FLSC_BIT_EWCLOSED];
                        stat_q  <= cyc_rdata;
                        state_q <= ST_SEQ;
                    end
                end
                ST_POST: begin
                    if (cyc_done) begin
                        // Closed window after the add: the sector may have been dropped
                        rej_q  <= cyc_rdata[`FLSC_BIT_EWCLOSED];
                        stat_q <= cyc_rdata;
                        if (poll_q) begin
                            state_q <= ST_PA;
                        end else begin
                            state_q <= ST_IDLE;
                            busy_q  <= 1'b0;
                            done_q  <= 1'b1;
                        end
                    end
                end
                ST_PA: begin
                    if (cyc_done) begin
                        first_q <= cyc_rdata;
                        stat_q  <= cyc_rdata;
                        state_q <= ST_PB;
                    end
                end
                ST_PB: begin
                    if (cyc_done) begin
                        stat_q <= cyc_rdata;
                        if (same) begin
                            state_q <= ST_FIN;
                        end else if (cyc_rdata[`FLSC_BIT_TLFAIL]) begin
                            state_q <= ST_RA;
                        end else begin
                            state_q <= ST_PA;
                        end
                    end
                end
                ST_RA: begin
                    if (cyc_done) begin
                        first_q <= cyc_rdata;
                        stat_q  <= cyc_rdata;
                        state_q <= ST_RB;
                    end
                end
                ST_RB: begin
                    if (cyc_done) begin
                        stat_q <= cyc_rdata;
                        if (same) begin
                            state_q <= ST_FIN;
                        end else begin
                            fail_q  <= 1'b1;
                            state_q <= ST_RST;
                        end
                    end
                end
                ST_FIN: begin
                    if (cyc_done) begin
                        rdata_q <= cyc_rdata;
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                    end
                end
                ST_RST: begin
                    if (cyc_done) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end
endmodule

// >>> test/flsc_checker.sv
`timescale 1ns/10ps
module flsc_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [18:0] fl_addr,
    input wire logic        fl_dq_oe,
    input wire logic        fl_ce_n,
    input wire logic        fl_oe_n,
    input wire logic        fl_we_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_READY_ONE_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("pready not on second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside access end");
    AST_READ_PULSE: assert property ($fell(fl_oe_n) |-> !fl_oe_n[*4] ##1 fl_oe_n)
        else $error("output strobe not four cycles");
    AST_WRITE_PULSE: assert property ($fell(fl_we_n) |-> !fl_we_n[*2] ##1 fl_we_n)
        else $error("write strobe not two cycles");
    AST_CE_AFTER_READ: assert property ($rose(fl_oe_n) |-> !fl_ce_n ##1 fl_ce_n)
        else $error("chip select not released after read");
    AST_ADDR_HELD: assert property (!fl_ce_n[*2] |-> $stable(fl_addr))
        else $error("flash address moved inside cycle");
    AST_NO_CLASH: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n && !fl_ce_n)
        else $error("data driven during read");
    AST_WRITE_RELEASE: assert property ($rose(fl_we_n) |-> fl_dq_oe ##1 !fl_dq_oe && fl_ce_n)
        else $error("write cycle not closed in time");

    cover property (pslverr);
    cover property ($fell(fl_we_n));
    cover property ($fell(fl_oe_n));
endmodule

bind flsc_top flsc_checker i_flsc_checker (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pready  (pready),
    .pslverr (pslverr),
    .fl_addr (fl_addr),
    .fl_dq_oe(fl_dq_oe),
    .fl_ce_n (fl_ce_n),
    .fl_oe_n (fl_oe_n),
    .fl_we_n (fl_we_n)
);

// >>> test/flsc_flash_model.sv
`timescale 1ns/10ps
module flsc_flash_model #(
    parameter int PROG_RD  = 3,
    parameter int FAIL_RD  = 4,
    parameter int ERASE_RD = 6,
    parameter int WIN_RD   = 3,
    parameter int PROT     = 7
) (
    input  wire logic [18:0] fl_addr,
    input  wire logic [7:0]  fl_dq_o,
    input  wire logic        fl_dq_oe,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_we_n,
    output logic      [7:0]  fl_dq_i
);
    logic [7:0] mem [0:255];
    logic [7:0] sel_q = '0, pdat_q = '0, cmd_q = '0, last_q = '0, st;
    logic       tog_q = 0, tog2_q = 0, fail_q = 0, bad_q = 0;
    logic       erase_q = 0, susp_q = 0, arm_q = 0;
    int         busy_q = 0, win_q = 0, resets = 0;
    wire  [2:0] sect = fl_addr[18:16];
    wire  [7:0] mi = {fl_addr[18:16], fl_addr[4:0]};

    initial foreach (mem[i]) mem[i] = 8'hff;

    always_comb begin
        if (susp_q && !sel_q[sect]) st = mem[mi];
        else if (erase_q) st = {susp_q, tog_q, 2'b00, win_q >= WIN_RD,
                                tog2_q & sel_q[sect], 2'b00};
        else if (busy_q > 0) st = {~pdat_q[7], tog_q, fail_q, 5'h00};
        else st = mem[mi];
        // Released bus shows the inverse so stale data never looks valid
        fl_dq_i = (!fl_ce_n && !fl_oe_n) ? st : ~last_q;
    end

    always @(posedge fl_oe_n) if (!fl_ce_n) begin
        last_q = st;
        if (sel_q[sect]) tog2_q = ~tog2_q;
        if (erase_q && susp_q) begin
            // Frozen while suspended
        end else if (erase_q && win_q < WIN_RD) begin
            tog_q = ~tog_q;
            win_q++;
            if (win_q == WIN_RD) busy_q = ERASE_RD;
        end else if (busy_q > 0) begin
            tog_q = ~tog_q;
            if (!fail_q) busy_q--;
            if (busy_q == 0 && bad_q) begin
                fail_q = 1;
                busy_q = 1;
            end else if (busy_q == 0 && erase_q) begin
                erase_q = 0;
                foreach (mem[i]) if (sel_q[i[7:5]]) mem[i] = 8'hff;
            end
        end
    end

    always @(posedge fl_we_n) if (!fl_ce_n) begin
        if (erase_q && win_q >= WIN_RD && !susp_q && fl_dq_o != 8'hb0) begin
            // Ignored once the window has closed
        end else if (fl_dq_o == 8'hf0) begin
            {busy_q, fail_q, bad_q, erase_q, susp_q, arm_q} = '0;
            resets++;
        end else if (cmd_q == 8'ha0) begin
            pdat_q = fl_dq_o;
            if (sect == PROT) busy_q = 2;
            else if ((fl_dq_o & ~mem[mi]) != 0) begin
                bad_q = 1;
                busy_q = FAIL_RD;
            end else begin
                mem[mi] = fl_dq_o;
                busy_q = PROG_RD;
            end
        end else if (fl_dq_o == 8'h30 && (arm_q && cmd_q == 8'h55 || erase_q && !susp_q)) begin
            if (!erase_q) sel_q = '0;
            erase_q = 1;
            arm_q = 0;
            win_q = 0;
            sel_q[sect] = (sect != PROT);
        end else if (fl_dq_o == 8'h10 && arm_q && cmd_q == 8'h55) begin
            erase_q = 1;
            arm_q = 0;
            win_q = WIN_RD;
            busy_q = ERASE_RD;
            sel_q = ~(8'h01 << PROT);
        end else if (fl_dq_o == 8'hb0 && erase_q) susp_q = 1;
        else if (fl_dq_o == 8'h30 && susp_q) susp_q = 0;
        else if (fl_dq_o == 8'h80) arm_q = 1;
        cmd_q = fl_dq_o;
    end
endmodule

// >>> test/flsc_top_tb_top.sv
`timescale 1ns/10ps
module flsc_top_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
    logic [7:0]  fl_dq_i, fl_dq_o;
    logic [18:0] fl_addr;
    int          mismatches = 0, checks = 0;

    flsc_top i_flsc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_dq_i(fl_dq_i), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));
    flsc_flash_model i_flsc_flash_model (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
        .fl_dq_i(fl_dq_i));

    initial forever #12.5 pclk = ~pclk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            end_sim;
        end
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk("write error", 32'(exp_err), 32'(e));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk("read data", exp, q & m);
        chk("read error", 32'(exp_err), 32'(e));
    endtask

    task automatic wait_idle;
        logic [31:0] q;
        logic        e;
        int          n;
        n = 0;
        do begin
            apb(1'b0, 8'h0c, 32'h0, q, e);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            mismatches++;
            end_sim;
        end
    endtask

    task automatic run(input logic [2:0] op, input logic [18:0] a, input logic poll);
        wr(8'h04, {13'h0, a}, 1'b0);
        wr(8'h00, {27'h0, poll, 1'b1, op}, 1'b0);
    endtask

    task automatic t_regs;
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, '1, 1'b0);
        rd(8'h14, 32'h0, '1, 1'b1);
        wr(8'h18, 32'h5, 1'b1);
    endtask

    task automatic t_prog;
        wr(8'h08, 32'h5a, 1'b0);
        run(3'd1, 19'h10005, 1'b1);
        wr(8'h04, 32'h0, 1'b1);
        wait_idle;
        rd(8'h04, 32'h10005, '1, 1'b0);
        rd(8'h0c, 32'h5a02, 32'hff07, 1'b0);
        chk("stored byte", 32'h5a, 32'(i_flsc_flash_model.mem[8'h25]));
        run(3'd0, 19'h10005, 1'b0);
        wait_idle;
        rd(8'h10, 32'h5a, '1, 1'b0);
    endtask

    task automatic t_fail;
        int r0;
        r0 = i_flsc_flash_model.resets;
        wr(8'h08, 32'hff, 1'b0);
        run(3'd1, 19'h10005, 1'b1);
        wait_idle;
        rd(8'h0c, 32'h06, 32'h07, 1'b0);
        chk("reset count", 32'(r0 + 1), 32'(i_flsc_flash_model.resets));
        run(3'd0, 19'h10005, 1'b0);
        wait_idle;
        rd(8'h10, 32'h5a, '1, 1'b0);
    endtask

    task automatic t_erase;
        run(3'd2, 19'h20000, 1'b0);
        wait_idle;
        run(3'd3, 19'h30000, 1'b0);
        wait_idle;
        rd(8'h0c, 32'h02, 32'h1e, 1'b0);
        for (int i = 0; i < 2; i++) begin
            run(3'd0, 19'h20000, 1'b0);
            wait_idle;
        end
        run(3'd3, 19'h40000, 1'b0);
        wait_idle;
        rd(8'h0c, 32'h1a, 32'h1e, 1'b0);
        chk("selected sectors", 32'h0c, 32'(i_flsc_flash_model.sel_q));
        run(3'd5, 19'h20000, 1'b0);
        wait_idle;
        chk("suspended", 32'h1, 32'(i_flsc_flash_model.susp_q));
        run(3'd0, 19'h10005, 1'b0);
        wait_idle;
        rd(8'h10, 32'h5a, '1, 1'b0);
        run(3'd6, 19'h20000, 1'b0);
        wait_idle;
        chk("resumed", 32'h0, 32'(i_flsc_flash_model.susp_q));
        run(3'd0, 19'h20000, 1'b1);
        wait_idle;
        rd(8'h10, 32'hff, '1, 1'b0);
        chk("other sector kept", 32'h5a, 32'(i_flsc_flash_model.mem[8'h25]));
    endtask

    task automatic t_chip;
        int r0;
        run(3'd2, 19'h70000, 1'b1);
        wait_idle;
        rd(8'h0c, 32'h02, 32'h07, 1'b0);
        wr(8'h08, 32'h00, 1'b0);
        run(3'd1, 19'h70001, 1'b1);
        wait_idle;
        rd(8'h10, 32'hff, '1, 1'b0);
        run(3'd4, 19'h00000, 1'b1);
        wait_idle;
        run(3'd0, 19'h10005, 1'b0);
        wait_idle;
        rd(8'h10, 32'hff, '1, 1'b0);
        r0 = i_flsc_flash_model.resets;
        run(3'd7, 19'h00000, 1'b0);
        wait_idle;
        chk("reset count", 32'(r0 + 1), 32'(i_flsc_flash_model.resets));
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_prog;
        t_fail;
        t_erase;
        t_chip;
        end_sim;
    end
endmodule
